// ===== spcs_defines.svh
`ifndef SPCS_DEFINES_SVH
`define SPCS_DEFINES_SVH

// ----------------------------------------------------------------
// control register layout
// ----------------------------------------------------------------
`define SPCS_CTRL_RST   8'h00
`define SPCS_B_MODE_HI  7
`define SPCS_B_MODE_LO  6
`define SPCS_B_MP       5
`define SPCS_B_REN      4
`define SPCS_B_TX_NINE  3
`define SPCS_B_RX_NINE  2
`define SPCS_B_TX_DONE  1
`define SPCS_B_RX_DONE  0

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define SPCS_M0_DIV_LAST  3'h5
`define SPCS_M0_SCLK_HI   3'h3
`define SPCS_M0_BIT_LAST  4'h7
`define SPCS_OS_MID       4'h7
`define SPCS_OS_END       4'hF
`define SPCS_TX_NB8       4'h9
`define SPCS_TX_NB9       4'hA
`define SPCS_RX_LAST8     4'h7
`define SPCS_RX_LAST9     4'h8

`endif

// ===== spcs_pkg.sv
package spcs_pkg;

    // ------------------------------------------------------------
    // modes and receiver states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SPCS_M_SHIFT = 2'b00,
        SPCS_M_UART8 = 2'b01,
        SPCS_M_FIX9  = 2'b10,
        SPCS_M_VAR9  = 2'b11
    } spcs_mode_t;

    typedef enum logic [1:0] {
        SPCS_RX_IDLE  = 2'b00,
        SPCS_RX_START = 2'b01,
        SPCS_RX_DATA  = 2'b10,
        SPCS_RX_STOP  = 2'b11
    } spcs_rx_st_t;

    // ------------------------------------------------------------
    // state records
    // ------------------------------------------------------------
    typedef struct packed {
        spcs_mode_t  mode;
        logic        mp;
        logic        ren;
        logic        tx_nine;
        logic        rx_nine;
        logic        tx_done;
        logic        rx_done;
        logic        fe;
        logic [7:0]  rdata;
        logic        half;
        logic        rxd_prev;
        logic        tx_busy;
        logic [10:0] tx_sh;
        logic [3:0]  tx_cnt;
        logic [3:0]  tx_sub;
        logic        txd;
        spcs_rx_st_t rx_st;
        logic [3:0]  rx_sub;
        logic [3:0]  rx_cnt;
        logic [8:0]  rx_sh;
        logic        push;
        logic [7:0]  push_data;
        logic        m0_busy;
        logic        m0_rx;
        logic [2:0]  m0_div;
        logic [3:0]  m0_cnt;
        logic [7:0]  m0_sh;
        logic        m0_oe;
    } spcs_state_t;

    typedef struct packed {
        logic       out_valid;
        logic [7:0] out_data;
        logic       skid_valid;
        logic [7:0] skid_data;
    } spcs_buf_t;

endpackage

// ===== spcs_rx_buffer.sv
`timescale 1ns/1ps
// two-entry buffer: output register plus one skid entry
module spcs_rx_buffer #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         ce,
    // fill side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // drain side
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    import spcs_pkg::*;

    typedef struct packed {
        logic         out_valid;
        logic [W-1:0] out_data;
        logic         skid_valid;
        logic [W-1:0] skid_data;
    } spcs_fifo_t;

    spcs_fifo_t s_r;
    spcs_fifo_t s_nxt;

    // move skid forward when output frees, else catch input
    always_comb begin
        s_nxt = s_r;
        if (out_ready || !s_r.out_valid) begin
            if (s_r.skid_valid) begin
                s_nxt.out_valid  = 1'h1;
                s_nxt.out_data   = s_r.skid_data;
                s_nxt.skid_valid = 1'h0;
            end else begin
                s_nxt.out_valid = in_valid;
                s_nxt.out_data  = in_data;
            end
        end else if (in_valid && !s_r.skid_valid) begin
            s_nxt.skid_valid = 1'h1;
            s_nxt.skid_data  = in_data;
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign in_ready  = !s_r.skid_valid; // full when skid holds a word
    assign out_valid = s_r.out_valid;
    assign out_data  = s_r.out_data;

endmodule // spcs_rx_buffer

// ===== spcs_serial_port_control.sv
`timescale 1ns/1ps
`include "spcs_defines.svh"

// Operation
// - nine-bit filter drops frames with ninth zero
// - eight-bit filter drops frames without stop
// - reception starts only while receive enable set
// - nine-bit frames send software ninth bit
// - nine-bit frames store received ninth bit
// - eight-bit mode stores received stop bit
// - shift mode leaves received ninth untouched
// - transmit done at stop start or bit8
// - transmit done cleared only by software
// - bit seven shows mode or framing error
// - framing error sticky until software clears
// - start conditions for transmit and receive
// - uart frame: start, data lsb first, ninth in nine-bit modes, stop
module spcs_serial_port_control (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       ce,
    // control register access
    input  wire logic       ctrl_wr,
    input  wire logic [7:0] ctrl_wdata,
    output logic [7:0]      ctrl_rdata,
    input  wire logic       fe_view_select,
    input  wire logic       baud_doubler,
    // transmit data
    input  wire logic       txbuf_wr,
    input  wire logic [7:0] txbuf_wdata,
    output logic            tx_busy,
    // received data stream
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    input  wire logic       rx_ready,
    // baud source for variable modes, 16x bit rate
    input  wire logic       baud_tick,
    // serial pins
    input  wire logic       rxd_in,
    output logic            rxd_out,
    output logic            rxd_oe,
    output logic            txd_out
);
    import spcs_pkg::*;

    spcs_state_t s_r;
    spcs_state_t s_nxt;
    logic        buf_ready;
    logic        tick;
    logic        tx_end;
    logic        rx_hit;
    logic        rx_accept;
    logic [3:0]  tx_nb;

    // ------------------------------------------------------------
    // bit rate and event helpers
    // ------------------------------------------------------------
    // rate by mode
    assign tick = (s_r.mode == SPCS_M_FIX9) ? (baud_doubler | s_r.half)
                                            : baud_tick;
    assign tx_nb  = s_r.mode[1] ? `SPCS_TX_NB9 : `SPCS_TX_NB8;
    assign tx_end = s_r.tx_busy && (s_r.mode != SPCS_M_SHIFT) && tick &&
                    (s_r.tx_sub == `SPCS_OS_END);
    assign rx_hit = (s_r.rx_st == SPCS_RX_STOP) && tick &&
                    (s_r.rx_sub == `SPCS_OS_END);
    assign rx_accept = (s_r.mode == SPCS_M_UART8) ? !(s_r.mp && !rxd_in)
                                                  : !(s_r.mp && !s_r.rx_sh[8]);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt          = s_r;
        s_nxt.half     = ~s_r.half;
        s_nxt.rxd_prev = rxd_in;
        s_nxt.push     = 1'h0;
        // software write, hardware sets below win over clears
        if (ctrl_wr) begin
            if (fe_view_select) begin
                s_nxt.fe = ctrl_wdata[`SPCS_B_MODE_HI];
            end else begin
                s_nxt.mode[1] = ctrl_wdata[`SPCS_B_MODE_HI];
            end
            s_nxt.mode[0] = ctrl_wdata[`SPCS_B_MODE_LO];
            s_nxt.mp      = ctrl_wdata[`SPCS_B_MP];
            s_nxt.ren     = ctrl_wdata[`SPCS_B_REN];
            s_nxt.tx_nine = ctrl_wdata[`SPCS_B_TX_NINE];
            s_nxt.rx_nine = ctrl_wdata[`SPCS_B_RX_NINE];
            s_nxt.tx_done = ctrl_wdata[`SPCS_B_TX_DONE];
            s_nxt.rx_done = ctrl_wdata[`SPCS_B_RX_DONE];
        end
        // shift-register mode engine
        if (s_r.mode == SPCS_M_SHIFT) begin
            if (!s_r.m0_busy) begin
                if (txbuf_wr) begin
                    s_nxt.m0_busy = 1'h1;
                    s_nxt.m0_rx   = 1'h0;
                    s_nxt.tx_busy = 1'h1;
                    s_nxt.m0_sh   = txbuf_wdata;
                    s_nxt.m0_div  = 3'h0;
                    s_nxt.m0_cnt  = 4'h0;
                end else if (s_r.ren && !s_r.rx_done && buf_ready) begin
                    s_nxt.m0_busy = 1'h1;
                    s_nxt.m0_rx   = 1'h1;
                    s_nxt.m0_div  = 3'h0;
                    s_nxt.m0_cnt  = 4'h0;
                end
            end else begin
                s_nxt.m0_div = s_r.m0_div + 3'h1;
                if (s_r.m0_rx && s_r.m0_div == `SPCS_M0_SCLK_HI) begin
                    s_nxt.m0_sh = {rxd_in, s_r.m0_sh[7:1]};
                end
                if (s_r.m0_div == `SPCS_M0_DIV_LAST) begin
                    s_nxt.m0_div = 3'h0;
                    s_nxt.m0_cnt = s_r.m0_cnt + 4'h1;
                    if (!s_r.m0_rx) begin
                        s_nxt.m0_sh = {1'h1, s_r.m0_sh[7:1]};
                    end
                    if (s_r.m0_cnt == `SPCS_M0_BIT_LAST) begin
                        s_nxt.m0_busy = 1'h0;
                        if (s_r.m0_rx) begin
                            s_nxt.rx_done   = 1'h1;
                            s_nxt.push      = 1'h1;
                            s_nxt.push_data = s_r.m0_sh;
                        end else begin
                            s_nxt.tx_done = 1'h1;
                            s_nxt.tx_busy = 1'h0;
                        end
                    end
                end
            end
        end else begin
            // uart transmitter
            if (!s_r.tx_busy && txbuf_wr) begin
                s_nxt.tx_busy = 1'h1;
                s_nxt.tx_sh   = {1'h1, (s_r.mode[1] ? s_nxt.tx_nine : 1'h1),
                                 txbuf_wdata, 1'h0};
                s_nxt.tx_cnt  = 4'h0;
                s_nxt.tx_sub  = 4'h0;
            end else if (s_r.tx_busy && tick) begin
                s_nxt.tx_sub = s_r.tx_sub + 4'h1;
                if (tx_end) begin
                    s_nxt.tx_sh  = {1'h1, s_r.tx_sh[10:1]};
                    s_nxt.tx_cnt = s_r.tx_cnt + 4'h1;
                    if (s_r.tx_cnt + 4'h1 == tx_nb) begin
                        s_nxt.tx_done = 1'h1;
                    end
                    if (s_r.tx_cnt == tx_nb) begin
                        s_nxt.tx_busy = 1'h0;
                    end
                end
            end
            // uart receiver
            unique case (s_r.rx_st)
                SPCS_RX_IDLE: begin
                    if (s_r.ren && buf_ready && s_r.rxd_prev && !rxd_in) begin
                        s_nxt.rx_st  = SPCS_RX_START;
                        s_nxt.rx_sub = 4'h0;
                    end
                end
                SPCS_RX_START: begin
                    if (tick) begin
                        s_nxt.rx_sub = s_r.rx_sub + 4'h1;
                        if (s_r.rx_sub == `SPCS_OS_MID) begin
                            s_nxt.rx_st  = rxd_in ? SPCS_RX_IDLE
                                                  : SPCS_RX_DATA;
                            s_nxt.rx_sub = 4'h0;
                            s_nxt.rx_cnt = 4'h0;
                        end
                    end
                end
                SPCS_RX_DATA: begin
                    if (tick) begin
                        s_nxt.rx_sub = s_r.rx_sub + 4'h1;
                        if (s_r.rx_sub == `SPCS_OS_END) begin
                            s_nxt.rx_sh  = {rxd_in, s_r.rx_sh[8:1]};
                            s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
                            if (s_r.rx_cnt == (s_r.mode[1] ? `SPCS_RX_LAST9
                                                          : `SPCS_RX_LAST8)) begin
                                s_nxt.rx_st = SPCS_RX_STOP;
                            end
                        end
                    end
                end
                SPCS_RX_STOP: begin
                    if (tick) begin
                        s_nxt.rx_sub = s_r.rx_sub + 4'h1;
                    end
                    if (rx_hit) begin
                        s_nxt.rx_st = SPCS_RX_IDLE;
                        if (!rxd_in) begin
                            s_nxt.fe = 1'h1;
                        end
                        if (rx_accept) begin
                            s_nxt.rx_done = 1'h1;
                            s_nxt.push    = 1'h1;
                            s_nxt.rx_nine = (s_r.mode == SPCS_M_UART8)
                                         ? rxd_in : s_r.rx_sh[8];
                            s_nxt.push_data = s_r.mode[1] ? s_r.rx_sh[7:0]
                                                          : s_r.rx_sh[8:1];
                        end
                    end
                end
            endcase
        end
        // pin images and read-back
        s_nxt.m0_oe = s_nxt.m0_busy && !s_nxt.m0_rx;
        if (s_nxt.mode == SPCS_M_SHIFT) begin
            s_nxt.txd = !(s_nxt.m0_busy && (s_nxt.m0_div < `SPCS_M0_SCLK_HI));
        end else begin
            s_nxt.txd = s_nxt.tx_busy ? s_nxt.tx_sh[0] : 1'h1;
        end
        s_nxt.rdata = {(fe_view_select ? s_nxt.fe : s_nxt.mode[1]),
                       s_nxt.mode[0], s_nxt.mp, s_nxt.ren, s_nxt.tx_nine,
                       s_nxt.rx_nine, s_nxt.tx_done, s_nxt.rx_done};
    end

    // state register, frozen while ce is low
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r          <= '0;
            s_r.rxd_prev <= 1'h1;
            s_r.txd      <= 1'h1;
            s_r.rdata    <= `SPCS_CTRL_RST;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // receive buffer
    // ------------------------------------------------------------
    spcs_rx_buffer #(
        .W (8)
    ) u_rx_buffer (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (s_r.push),
        .in_data   (s_r.push_data),
        .in_ready  (buf_ready),
        .out_valid (rx_valid),
        .out_data  (rx_data),
        .out_ready (rx_ready)
    );

    // outputs straight from flops
    assign ctrl_rdata = s_r.rdata;
    assign tx_busy    = s_r.tx_busy;
    assign rxd_out    = s_r.m0_sh[0];
    assign rxd_oe     = s_r.m0_oe;
    assign txd_out    = s_r.txd;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_no_sw_write;
        ce && !ctrl_wr;
    endsequence

    sequence s_stop_hit_uart;
        ce && rx_hit && s_r.mode != SPCS_M_SHIFT;
    endsequence

    a_rx_needs_enable: assert property (
        (ce && s_r.rx_st == SPCS_RX_IDLE && !s_r.ren &&
         s_r.mode != SPCS_M_SHIFT) |=> s_r.rx_st == SPCS_RX_IDLE)
        else $error("receiver left idle while disabled");

    a_filter_ninth: assert property (
        (s_stop_hit_uart and s_no_sw_write) ##0 (s_r.mode[1] && s_r.mp &&
         !s_r.rx_sh[8] && !s_r.rx_done) |=> !s_r.rx_done && !s_r.push)
        else $error("frame with ninth bit zero raised receive done");

    a_filter_stop: assert property (
        (s_stop_hit_uart and s_no_sw_write) ##0 (s_r.mode == SPCS_M_UART8
         && s_r.mp && !rxd_in && !s_r.rx_done) |=> !s_r.rx_done)
        else $error("frame without stop raised receive done");

    a_tx_ninth_load: assert property (
        (ce && txbuf_wr && !s_r.tx_busy && s_r.mode[1] && !ctrl_wr)
        |=> s_r.tx_sh[9] == $past(s_r.tx_nine) && s_r.tx_sh[0] == 1'h0)
        else $error("ninth bit not loaded into frame");

    a_rx_ninth_store: assert property (
        (s_stop_hit_uart ##0 rx_accept) |=> s_r.rx_nine == ((s_r.mode ==
         SPCS_M_UART8) ? $past(rxd_in) : $past(s_r.rx_sh[8])))
        else $error("received ninth bit not stored");

    // shift mode keeps stored ninth bit
    a_m0_ninth_hold: assert property (
        (s_no_sw_write ##0 s_r.mode == SPCS_M_SHIFT) |=> $stable(s_r.rx_nine))
        else $error("shift mode changed received ninth bit");

    a_tx_done_stop: assert property (
        (ce && tx_end && s_r.tx_cnt + 4'h1 == tx_nb) |=> s_r.tx_done ##0
        s_r.tx_busy [*1])
        else $error("transmit done missing at stop bit");

    a_tx_done_sticky: assert property (
        (s_r.tx_done && !(ctrl_wr && !ctrl_wdata[`SPCS_B_TX_DONE]))
        |=> s_r.tx_done)
        else $error("transmit done cleared without software");

    a_fe_sticky: assert property (
        (s_r.fe && !(ctrl_wr && fe_view_select)) |=> s_r.fe)
        else $error("framing error cleared without software");

    a_m0_rx_start: assert property (
        (ce && s_r.mode == SPCS_M_SHIFT && !s_r.m0_busy && s_r.ren &&
         !s_r.rx_done && buf_ready && !txbuf_wr && !ctrl_wr)
        |=> s_r.m0_busy && s_r.m0_rx)
        else $error("shift mode reception did not start");

endmodule // spcs_serial_port_control

// ===== spcs_peer.sv
`timescale 1ns/1ps
// remote serial peer, 16 clocks per bit, line idles high
module spcs_peer (
    // clock
    input  wire logic clk_sys,
    // capture control
    input  wire logic listen,
    // serial lines
    input  wire logic txd,
    output logic      rxd
);
    logic [9:0] cap;

    initial begin
        rxd = 1'b1;
        cap = 10'h000;
    end

    // ------------------------------------------------------------
    // frame driver
    // ------------------------------------------------------------
    // start low, data lsb first, ninth if nb9, stop
    task automatic send(input logic [8:0] d, input logic nb9,
                        input logic stp);
        logic [10:0] f;
        int          n;
        f = nb9 ? {stp, d, 1'b0} : {1'b1, stp, d[7:0], 1'b0};
        n = nb9 ? 11 : 10;
        for (int i = 0; i < n; i++) begin
            rxd = f[i];
            repeat (16) @(posedge clk_sys);
            #1;
        end
        rxd = 1'b1;
        tick_idle();
    endtask

    // idle line between frames
    task automatic tick_idle();
        repeat (4) @(posedge clk_sys);
        #1;
    endtask

    // ------------------------------------------------------------
    // frame capture at mid-bit
    // ------------------------------------------------------------
    always begin
        @(negedge txd);
        if (listen) begin
            repeat (8) @(posedge clk_sys);
            for (int i = 0; i < 10; i++) begin
                repeat (16) @(posedge clk_sys);
                cap[i] = txd;
            end
        end
    end
endmodule // spcs_peer

// ===== serial_port_control_status_tb.sv
`timescale 1ns/1ps
module serial_port_control_status_tb;
    logic       clk_sys, rst, ce, ctrl_wr, fe_view_select, baud_doubler;
    logic [7:0] ctrl_wdata, ctrl_rdata, txbuf_wdata, rx_data;
    logic       txbuf_wr, tx_busy, rx_valid, rx_ready, baud_tick;
    logic       rxd_in, rxd_out, rxd_oe, txd_out, peer_rxd, listen;
    int         n_fail, tests_run, cycles;

    // shared data pin: port drives it only in shift mode transmit
    assign rxd_in = rxd_oe ? rxd_out : peer_rxd;

    spcs_serial_port_control spcs_serial_port_control_inst (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
        .fe_view_select(fe_view_select), .baud_doubler(baud_doubler),
        .txbuf_wr(txbuf_wr), .txbuf_wdata(txbuf_wdata), .tx_busy(tx_busy),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .baud_tick(baud_tick), .rxd_in(rxd_in), .rxd_out(rxd_out),
        .rxd_oe(rxd_oe), .txd_out(txd_out));

    spcs_peer spcs_peer_inst (.clk_sys(clk_sys), .listen(listen),
        .txd(txd_out), .rxd(peer_rxd));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    always #20 clk_sys = ~clk_sys;

    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 12000) begin
            n_fail++;
            results();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] v);
        ctrl_wr = 1'b1;
        ctrl_wdata = v;
        tick(1);
        ctrl_wr = 1'b0;
        tick(1);
    endtask

    task automatic tx_frame(input logic [7:0] d);
        txbuf_wdata = d;
        txbuf_wr = 1'b1;
        tick(1);
        txbuf_wr = 1'b0;
        for (int i = 0; i < 400 && ctrl_rdata[1] !== 1'b1; i++) tick(1);
        chk({6'h00, tx_busy, txd_out}, 8'h03);
        for (int i = 0; i < 400 && tx_busy !== 1'b0; i++) tick(1);
        tick(30);
    endtask

    task automatic take(input logic [7:0] d);
        chk({7'h00, rx_valid}, 8'h01);
        chk(rx_data, d);
        rx_ready = 1'b1;
        tick(1);
        rx_ready = 1'b0;
        tick(1);
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic results();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {clk_sys, ctrl_wr, fe_view_select, baud_doubler, txbuf_wr} = '0;
        {rx_ready, listen, ctrl_wdata, txbuf_wdata} = '0;
        {rst, ce, baud_tick} = 3'b111;
        {n_fail, tests_run, cycles} = '0;
        tick(5);
        rst = 1'b0;
        chk(ctrl_rdata, 8'h00);
        chk({5'h00, rxd_oe, rxd_out, txd_out}, 8'h01);
        wr(8'h50);
        chk(ctrl_rdata, 8'h50);
        done("reset");
        // eight-bit transmit, flag stays until cleared
        listen = 1'b1;
        tx_frame(8'hA5);
        chk(spcs_peer_inst.cap[7:0], 8'hA5);
        chk({7'h00, spcs_peer_inst.cap[8]}, 8'h01);
        tick(50);
        chk(ctrl_rdata, 8'h52);
        wr(8'h50);
        chk(ctrl_rdata, 8'h50);
        done("tx8");
        // nine-bit transmit with both ninth values
        for (int b = 0; b < 2; b++) begin
            wr(b ? 8'hD8 : 8'hD0);
            tx_frame(8'h3C);
            chk(spcs_peer_inst.cap[7:0], 8'h3C);
            chk({7'h00, spcs_peer_inst.cap[8]}, 8'(b));
            chk({7'h00, spcs_peer_inst.cap[9]}, 8'h01);
        end
        done("tx9");
        // fixed-rate nine-bit receive
        listen = 1'b0;
        baud_doubler = 1'b1;
        wr(8'h90);
        spcs_peer_inst.send(9'h15A, 1'b1, 1'b1);
        chk(ctrl_rdata, 8'h95);
        take(8'h5A);
        done("rx9");
        // address filter on ninth bit
        wr(8'hF0);
        spcs_peer_inst.send(9'h022, 1'b1, 1'b1);
        chk(ctrl_rdata & 8'h01, 8'h00);
        chk({7'h00, rx_valid}, 8'h00);
        spcs_peer_inst.send(9'h1C3, 1'b1, 1'b1);
        chk(ctrl_rdata & 8'h01, 8'h01);
        take(8'hC3);
        done("filter9");
        // eight-bit filter, framing error view and stickiness
        wr(8'h70);
        fe_view_select = 1'b1;
        spcs_peer_inst.send(9'h055, 1'b0, 1'b0);
        chk(ctrl_rdata & 8'h81, 8'h80);
        chk({7'h00, rx_valid}, 8'h00);
        spcs_peer_inst.send(9'h0AA, 1'b0, 1'b1);
        chk(ctrl_rdata & 8'h85, 8'h85);
        take(8'hAA);
        wr(8'h70);
        chk(ctrl_rdata, 8'h70);
        fe_view_select = 1'b0;
        tick(2);
        chk(ctrl_rdata, 8'h70);
        done("filter8");
        // stop bit lands in the ninth field
        wr(8'h50);
        spcs_peer_inst.send(9'h0F0, 1'b0, 1'b1);
        chk(ctrl_rdata, 8'h55);
        take(8'hF0);
        wr(8'h54);
        spcs_peer_inst.send(9'h00F, 1'b0, 1'b0);
        chk(ctrl_rdata, 8'h51);
        take(8'h0F);
        done("stop");
        // receive disabled
        wr(8'h40);
        spcs_peer_inst.send(9'h033, 1'b0, 1'b1);
        chk(ctrl_rdata, 8'h40);
        chk({7'h00, rx_valid}, 8'h00);
        done("ren");
        // buffer fills, third frame refused, then drains
        wr(8'h50);
        spcs_peer_inst.send(9'h011, 1'b0, 1'b1);
        spcs_peer_inst.send(9'h022, 1'b0, 1'b1);
        spcs_peer_inst.send(9'h033, 1'b0, 1'b1);
        take(8'h11);
        take(8'h22);
        chk({7'h00, rx_valid}, 8'h00);
        done("buffer");
        // shift mode receive; filter kept off by software
        // filter bit written as zero
        wr(8'h14);
        for (int i = 0; i < 200 && ctrl_rdata[0] !== 1'b1; i++) tick(1);
        tick(4);
        chk(ctrl_rdata, 8'h15);
        take(8'hFF);
        chk(ctrl_rdata, 8'h15);
        // shift mode transmit: data on rxd, clock low on txd
        txbuf_wdata = 8'h96;
        txbuf_wr = 1'b1;
        tick(1);
        txbuf_wr = 1'b0;
        chk({5'h00, rxd_oe, txd_out, rxd_out}, 8'h04);
        for (int i = 0; i < 8; i++) begin
            chk({7'h00, rxd_out}, {7'h00, txbuf_wdata[i]});
            tick(6);
        end
        chk(ctrl_rdata, 8'h17);
        chk({6'h00, rxd_oe, tx_busy}, 8'h00);
        done("shift");
        results();
    end
endmodule // serial_port_control_status_tb
